//--- src/dmarc_pkg.sv
// package for the dma register and command block: address codes,
// field positions, reset values and bit encodings.
// assumes a 4-bit host register address and an 8-bit host data bus.
package dmarc_pkg;

  // ==========================================================
  // widths
  localparam int CHANS = 4;
  localparam int WORD_W = 16;

  // ==========================================================
  // register address codes, address bit 3 high
  localparam logic [3:0] ADR_STATUS_CMD = 4'h8; // status read, command write
  localparam logic [3:0] ADR_REQUEST = 4'h9; // request write
  localparam logic [3:0] ADR_SMASK = 4'hA; // single mask bit write
  localparam logic [3:0] ADR_MODE = 4'hB; // mode write
  localparam logic [3:0] ADR_CLR_TOG = 4'hC; // clear byte toggle
  localparam logic [3:0] ADR_TEMP_MCLR = 4'hD; // temporary read, master clear
  localparam logic [3:0] ADR_CLR_MASK = 4'hE; // clear mask
  localparam logic [3:0] ADR_ALL_MASK = 4'hF; // all mask bits write
  localparam int ADR_GROUP_BIT = 3; // high selects the group above

  // ==========================================================
  // data bus field positions
  localparam int DB_CHSEL_LO = 0; // channel select field, bits 1:0
  localparam int DB_SET_BIT = 2; // set (1) or clear (0) for request/mask
  localparam int DB_MODE_LO = 2; // mode field sits in data bits 7:2
  localparam int CMD_M2M_BIT = 0; // command bit: memory-to-memory pair

  // stored mode field (data bits 7:2 shifted down by two)
  localparam int MODE_AUTOINIT = 2; // data bit 4
  localparam int MODE_DECR = 3; // data bit 5
  localparam int MODE_SEL_LO = 4; // data bits 7:6
  localparam logic [1:0] MODE_BLOCK = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [5:0] MODE_RST = 6'h00;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [3:0] REQ_RST = 4'h0;
  localparam logic [3:0] TC_RST = 4'h0;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] DB_IDLE = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;

endpackage

//--- src/dmarc_edge.sv
// leading-edge detector for an active-high level.
// assumes the level is synchronous to clk.
`timescale 1ns/100ps

module dmarc_edge (
  input wire logic clk,
  input wire logic rstn,
  input wire logic lvl,
  output logic start
);
  logic prev_r; // level seen one cycle earlier

  // ==========================================================
  // history
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  // pulse on the first cycle only
  assign start = lvl & ~prev_r;
endmodule // dmarc_edge

//--- src/dmarc_word.sv
// base/current register pair of one channel, loaded a byte at a time.
// assumes the parent gives one-cycle write, reload and step pulses.
`timescale 1ns/100ps

module dmarc_word #(
  parameter int W = dmarc_pkg::WORD_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_lo, // host writes low byte
  input wire logic wr_hi, // host writes high byte
  input wire logic [7:0] wr_data,
  input wire logic reload, // copy base into current
  input wire logic step, // one transfer done
  input wire logic down, // step counts downward
  output logic [W-1:0] cur, // current value, the only readable one
  output logic wrap // step from zero while counting down
);
  logic [W-1:0] base_r; // original value, never read by the host
  logic [W-1:0] cur_r;
  logic [W-1:0] cur_nxt;
  logic [W-1:0] base_nxt;
  logic [W-1:0] one;

  assign one = W'(dmarc_pkg::WORD_ONE);

  // ==========================================================
  // next values: host write beats reload beats step
  always_comb begin
    base_nxt = base_r;
    cur_nxt = cur_r;
    if (wr_lo || wr_hi) begin
      // base and current load together, dropping any count in flight
      if (wr_lo) base_nxt[7:0] = wr_data;
      if (wr_hi) base_nxt[W-1:8] = wr_data[W-9:0];
      cur_nxt = base_nxt;
    end else if (reload) begin
      cur_nxt = base_r;
    end else if (step) begin
      cur_nxt = down ? cur_r - one : cur_r + one;
    end
  end

  // ==========================================================
  // storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      base_r <= W'(dmarc_pkg::WORD_RST);
      cur_r <= W'(dmarc_pkg::WORD_RST);
    end else begin
      base_r <= base_nxt;
      cur_r <= cur_nxt;
    end
  end

  assign cur = cur_r;
  // terminal count fires on the 0000 to ffff borrow
  assign wrap = step & down & (cur_r == W'(dmarc_pkg::WORD_RST)) & ~wr_lo & ~wr_hi;
endmodule // dmarc_word

//--- src/dmarc_top.sv
// register and command logic of a four-channel dma controller:
// channel address/count pairs, command, mode, request, mask, status
// and temporary registers, the software commands and host read path.
// assumes a transfer engine outside that reports each transfer step,
// the active channel and the memory-to-memory data word, and a host
// whose strobes and address are synchronous to MCLK.
`timescale 1ns/100ps

//==========================================================
module dmarc_top #(
  parameter int NCH = dmarc_pkg::CHANS
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic IOR_STROBE_N,
  input wire logic IOW_STROBE_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] DB_IN,
  output logic [7:0] DB_OUT,
  output logic DB_OE,
  input wire logic PROG_COND,
  input wire logic [3:0] CHANNEL_REQUEST_IN,
  input wire logic [3:0] XFER_STEP,
  input wire logic END_OF_PROCESS_N,
  input wire logic [1:0] ACTIVE_CHAN,
  input wire logic TEMP_LOAD,
  input wire logic [7:0] TEMP_DATA,
  output logic [3:0] TERMINAL_COUNT,
  output logic [3:0] SERVICE_REQ,
  output logic [3:0] MASK_OUT,
  output logic [7:0] CMD_OUT
);

  // ==========================================================
  // host access qualification
  logic rd_lvl; // read strobe active on this chip
  logic wr_lvl; // write strobe active on this chip
  logic rd_go; // first cycle of a read
  logic wr_go; // first cycle of a write
  logic eop_lvl; // external end of process, active high
  logic eop_go; // its leading edge

  // host accesses only count in the program condition
  assign rd_lvl = ~CS_N & ~IOR_STROBE_N & IOW_STROBE_N & PROG_COND;
  assign wr_lvl = ~CS_N & ~IOW_STROBE_N & IOR_STROBE_N & PROG_COND;
  assign eop_lvl = ~END_OF_PROCESS_N;

  // act once per strobe, so a long strobe cannot flip the toggle twice
  dmarc_edge u_rd_edge (
    .clk(MCLK),
    .rstn(RSTN),
    .lvl(rd_lvl),
    .start(rd_go)
  );

  dmarc_edge u_wr_edge (
    .clk(MCLK),
    .rstn(RSTN),
    .lvl(wr_lvl),
    .start(wr_go)
  );

  dmarc_edge u_eop_edge (
    .clk(MCLK),
    .rstn(RSTN),
    .lvl(eop_lvl),
    .start(eop_go)
  );

  // ==========================================================
  // address decode
  logic grp_hi; // command group selected
  logic ch_acc; // channel register access, read or write
  logic [1:0] ch_sel; // channel picked by address bits 2:1
  logic is_cnt; // word count (1) or address (0)
  logic wr_cmd, wr_req, wr_smask, wr_mode;
  logic do_clr_tog, do_mclr, do_clr_mask, wr_amask;
  logic rd_status, rd_temp;

  assign grp_hi = REG_ADDR[dmarc_pkg::ADR_GROUP_BIT];
  assign ch_sel = REG_ADDR[2:1];
  assign is_cnt = REG_ADDR[0];
  assign ch_acc = ~grp_hi & (rd_go | wr_go);
  assign wr_cmd = wr_go & (REG_ADDR == dmarc_pkg::ADR_STATUS_CMD);
  assign wr_req = wr_go & (REG_ADDR == dmarc_pkg::ADR_REQUEST);
  assign wr_smask = wr_go & (REG_ADDR == dmarc_pkg::ADR_SMASK);
  assign wr_mode = wr_go & (REG_ADDR == dmarc_pkg::ADR_MODE);
  // the three commands look at the address only, data is ignored
  assign do_clr_tog = wr_go & (REG_ADDR == dmarc_pkg::ADR_CLR_TOG);
  assign do_mclr = wr_go & (REG_ADDR == dmarc_pkg::ADR_TEMP_MCLR);
  assign do_clr_mask = wr_go & (REG_ADDR == dmarc_pkg::ADR_CLR_MASK);
  assign wr_amask = wr_go & (REG_ADDR == dmarc_pkg::ADR_ALL_MASK);
  assign rd_status = rd_go & (REG_ADDR == dmarc_pkg::ADR_STATUS_CMD);
  assign rd_temp = rd_go & (REG_ADDR == dmarc_pkg::ADR_TEMP_MCLR);

  // master clear joins the reset pin for the control registers below only
  logic clr_n; // combined reset, active low
  assign clr_n = RSTN & ~do_mclr;

  // ==========================================================
  // state
  logic tog_r, tog_nxt; // byte toggle: 0 low byte, 1 high byte
  logic [7:0] cmd_r, cmd_nxt; // command register
  logic [5:0] mode_r [NCH]; // mode per channel
  logic [3:0] mask_r, mask_nxt; // hardware request masks
  logic [3:0] req_r, req_nxt; // software requests
  logic [3:0] tc_r, tc_nxt; // sticky terminal count status
  logic [7:0] temp_r, temp_nxt; // memory-to-memory hold word
  logic [7:0] db_r, db_nxt; // read data on the bus
  logic db_oe_r; // bus driven
  logic [3:0] tc_out_r; // terminal count pulses out
  logic [3:0] svc_r; // pending requests out

  // ==========================================================
  // channel address and count pairs
  logic [15:0] cur_adr [NCH];
  logic [15:0] cur_cnt [NCH];
  logic [3:0] cnt_wrap; // borrow from zero, per channel
  logic [3:0] eop_ch; // end of process, per channel
  logic [3:0] autoinit; // autoinit programmed, per channel
  logic [3:0] block_md; // block transfer mode, per channel
  logic m2m; // memory-to-memory pair enabled

  assign m2m = cmd_r[dmarc_pkg::CMD_M2M_BIT];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic hit_adr, hit_cnt; // this channel's address or count written
      assign hit_adr = wr_go & ~grp_hi & (ch_sel == 2'(g)) & ~is_cnt;
      assign hit_cnt = wr_go & ~grp_hi & (ch_sel == 2'(g)) & is_cnt;
      assign autoinit[g] = mode_r[g][dmarc_pkg::MODE_AUTOINIT];
      assign block_md[g] = mode_r[g][dmarc_pkg::MODE_SEL_LO +: 2] == dmarc_pkg::MODE_BLOCK;

      // address steps up or down per mode; both reload on autoinit
      dmarc_word u_adr (
        .clk(MCLK),
        .rstn(RSTN),
        .wr_lo(hit_adr & ~tog_r),
        .wr_hi(hit_adr & tog_r),
        .wr_data(DB_IN),
        .reload(eop_ch[g] & autoinit[g]),
        .step(XFER_STEP[g]),
        .down(mode_r[g][dmarc_pkg::MODE_DECR]),
        .cur(cur_adr[g]),
        .wrap()
      );

      // word count always counts down, one less than the transfers
      dmarc_word u_cnt (
        .clk(MCLK),
        .rstn(RSTN),
        .wr_lo(hit_cnt & ~tog_r),
        .wr_hi(hit_cnt & tog_r),
        .wr_data(DB_IN),
        .reload(eop_ch[g] & autoinit[g]),
        .step(XFER_STEP[g]),
        .down(1'b1),
        .cur(cur_cnt[g]),
        .wrap(cnt_wrap[g])
      );

      // end of process: own terminal count or the external pin;
      // in the memory pair channel 1's count also ends channel 0
      if (g == 0) begin : g_src
        assign eop_ch[g] = cnt_wrap[g] | (m2m & cnt_wrap[1]) | (eop_go & (ACTIVE_CHAN == 2'(g)));
      end else begin : g_oth
        assign eop_ch[g] = cnt_wrap[g] | (eop_go & (ACTIVE_CHAN == 2'(g)));
      end
    end
  endgenerate

  // ==========================================================
  // software request acceptance
  logic [1:0] db_ch; // channel field of the data bus
  logic db_set; // set or clear field
  logic req_ok; // a set request may be taken

  assign db_ch = DB_IN[dmarc_pkg::DB_CHSEL_LO +: 2];
  assign db_set = DB_IN[dmarc_pkg::DB_SET_BIT];
  // block mode only, and only channel 0 while the memory pair runs
  assign req_ok = block_md[db_ch] & (~m2m | (db_ch == 2'h0));

  // ==========================================================
  // next-state logic for the control registers
  always_comb begin
    cmd_nxt = cmd_r;
    mask_nxt = mask_r;
    req_nxt = req_r;
    tog_nxt = tog_r;
    temp_nxt = temp_r;
    // command register
    if (wr_cmd) cmd_nxt = DB_IN;
    // byte toggle
    if (do_clr_tog) begin
      tog_nxt = 1'b0;
    end else if (ch_acc) begin
      tog_nxt = ~tog_r;
    end
    // mask: host writes first, end of process sets on top unless autoinit
    if (wr_smask) mask_nxt[db_ch] = db_set;
    if (wr_amask) mask_nxt = DB_IN[3:0];
    if (do_clr_mask) mask_nxt = 4'h0;
    mask_nxt = mask_nxt | (eop_ch & ~autoinit);
    // software request: write, then clear on terminal count or eop
    if (wr_req) begin
      if (!db_set) begin
        req_nxt[db_ch] = 1'b0;
      end else if (req_ok) begin
        req_nxt[db_ch] = 1'b1;
      end
    end
    req_nxt = req_nxt & ~eop_ch;
    // temporary register keeps the last memory word
    if (TEMP_LOAD) temp_nxt = TEMP_DATA;
  end

  // terminal count status: a new count wins over the read clear
  assign tc_nxt = (rd_status ? 4'h0 : tc_r) | cnt_wrap;

  // ==========================================================
  // read path, current values only
  logic [15:0] rd_word; // current register of the addressed channel

  assign rd_word = is_cnt ? cur_cnt[ch_sel] : cur_adr[ch_sel];

  always_comb begin
    db_nxt = db_r;
    if (rd_go) begin
      if (!grp_hi) begin
        db_nxt = tog_r ? rd_word[15:8] : rd_word[7:0];
      end else if (rd_status) begin
        db_nxt = {svc_nxt(mask_r, req_r, CHANNEL_REQUEST_IN), tc_r};
      end else if (rd_temp) begin
        db_nxt = temp_r;
      end else begin
        // write-only codes answer with zero
        db_nxt = dmarc_pkg::DB_IDLE;
      end
    end
  end

  // pending service: unmasked hardware or any software request
  function automatic logic [3:0] svc_nxt(
    input logic [3:0] msk,
    input logic [3:0] sw,
    input logic [3:0] hw
  );
    svc_nxt = (hw & ~msk) | sw;
  endfunction

  // ==========================================================
  // registers cleared by reset or master clear
  always_ff @(posedge MCLK) begin
    if (!clr_n) begin
      cmd_r <= dmarc_pkg::CMD_RST;
      mask_r <= dmarc_pkg::MASK_RST;
      req_r <= dmarc_pkg::REQ_RST;
      tc_r <= dmarc_pkg::TC_RST;
      temp_r <= dmarc_pkg::TEMP_RST;
      tog_r <= 1'b0;
    end else begin
      cmd_r <= cmd_nxt;
      mask_r <= mask_nxt;
      req_r <= req_nxt;
      tc_r <= tc_nxt;
      temp_r <= temp_nxt;
      tog_r <= tog_nxt;
    end
  end

  // ==========================================================
  // mode registers; master clear leaves them, as the pin reset does not
  // name them either, but a power-up value is still defined
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NCH; i++) begin
        mode_r[i] <= dmarc_pkg::MODE_RST;
      end
    end else if (wr_mode) begin
      mode_r[db_ch] <= DB_IN[7:dmarc_pkg::DB_MODE_LO];
    end
  end

  // ==========================================================
  // bus drive: data held while the read strobe stays low
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      db_r <= dmarc_pkg::DB_IDLE;
      db_oe_r <= 1'b0;
    end else begin
      db_r <= db_nxt;
      db_oe_r <= rd_lvl;
    end
  end

  // ==========================================================
  // outputs toward the transfer engine
  always_ff @(posedge MCLK) begin
    if (!RSTN) begin
      tc_out_r <= dmarc_pkg::TC_RST;
      svc_r <= dmarc_pkg::REQ_RST;
    end else begin
      tc_out_r <= cnt_wrap;
      svc_r <= svc_nxt(mask_nxt, req_nxt, CHANNEL_REQUEST_IN);
    end
  end

  assign DB_OUT = db_r;
  assign DB_OE = db_oe_r;
  assign TERMINAL_COUNT = tc_out_r;
  assign SERVICE_REQ = svc_r;
  assign MASK_OUT = mask_r;
  assign CMD_OUT = cmd_r;

endmodule // dmarc_top

//--- testbench/dmarc_sva.sv
// checker for the dma register block, bound to its top module.
// assumes host strobes and address are synchronous to MCLK.
`timescale 1ns/100ps

module dmarc_sva #(
  parameter int NCH = dmarc_pkg::CHANS // channel count, handed on by bind
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic IOR_STROBE_N,
  input wire logic IOW_STROBE_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] DB_IN,
  input wire logic DB_OE,
  input wire logic PROG_COND,
  input wire logic [3:0] XFER_STEP,
  input wire logic [3:0] TERMINAL_COUNT,
  input wire logic [3:0] MASK_OUT,
  input wire logic [7:0] CMD_OUT
);
  // ==========================================================
  // clocking and host access sequences
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RSTN);

  // first cycle of an accepted write at one code
  sequence wr_take(logic [3:0] a);
    !CS_N && PROG_COND && !IOW_STROBE_N && IOR_STROBE_N && $past(IOW_STROBE_N) && REG_ADDR == a;
  endsequence
  // first cycle of an accepted read
  sequence rd_take;
    !CS_N && PROG_COND && !IOR_STROBE_N && IOW_STROBE_N && $past(IOR_STROBE_N);
  endsequence

  // ==========================================================
  // register writes and commands
  a_cmd_write: assert property (wr_take(4'h8) |=> CMD_OUT == $past(DB_IN))
    else $error("command write not taken");
  a_cmd_locked: assert property (!PROG_COND |=> $stable(CMD_OUT))
    else $error("command changed outside program condition");
  a_single_mask: assert property (wr_take(4'hA) |=> MASK_OUT[$past(DB_IN[1:0])] == $past(DB_IN[2]))
    else $error("single mask bit wrong");
  a_all_mask: assert property (wr_take(4'hF) |=> MASK_OUT == $past(DB_IN[3:0]))
    else $error("all mask write wrong");
  a_clr_mask: assert property (wr_take(4'hE) |-> ##1 MASK_OUT == 4'h0)
    else $error("clear mask left bits set");
  a_mclr_clears: assert property (wr_take(4'hD) |=> MASK_OUT == 4'hF && CMD_OUT == 8'h00)
    else $error("master clear incomplete");
  // ==========================================================
  // read path and terminal count
  a_rd_drive: assert property (rd_take |=> DB_OE)
    else $error("read not driven");
  a_oe_release: assert property (IOR_STROBE_N [*2] |-> !DB_OE)
    else $error("bus driven without read");
  // pulse only right after a step, and one cycle wide
  a_tc_pulse: assert property (TERMINAL_COUNT[2] |-> $past(XFER_STEP[2]) ##1 !TERMINAL_COUNT[2])
    else $error("terminal count pulse wrong");
endmodule // dmarc_sva

bind dmarc_top dmarc_sva #(.NCH(NCH)) dmarc_sva_i (.MCLK(MCLK), .RSTN(RSTN), .CS_N(CS_N),
  .IOR_STROBE_N(IOR_STROBE_N), .IOW_STROBE_N(IOW_STROBE_N), .REG_ADDR(REG_ADDR), .DB_IN(DB_IN),
  .DB_OE(DB_OE), .PROG_COND(PROG_COND), .XFER_STEP(XFER_STEP), .TERMINAL_COUNT(TERMINAL_COUNT),
  .MASK_OUT(MASK_OUT), .CMD_OUT(CMD_OUT));

//--- testbench/dmarc_host.sv
// host processor model: byte reads and writes on the register bus.
// assumes accesses are taken on MCLK rising edges, data one cycle later.
`timescale 1ns/100ps

module dmarc_host (
  input wire logic MCLK,
  output logic CS_N,
  output logic IOR_STROBE_N,
  output logic IOW_STROBE_N,
  output logic [3:0] REG_ADDR,
  output logic [7:0] DB_IN,
  input wire logic [7:0] DB_OUT
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    {CS_N, IOR_STROBE_N, IOW_STROBE_N, REG_ADDR, DB_IN} = {3'h7, 4'h0, 8'h00};
  end

  // write: hold one cycle, released data shows the inverse
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge MCLK);
    {CS_N, IOW_STROBE_N, REG_ADDR, DB_IN} = {2'h0, a, d};
    @(negedge MCLK);
    {CS_N, IOW_STROBE_N, DB_IN} = {2'h3, ~d};
    @(negedge MCLK);
  endtask

  // read: data is valid the cycle after the taking edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge MCLK);
    {CS_N, IOR_STROBE_N, REG_ADDR} = {2'h0, a};
    repeat (2) @(negedge MCLK);
    d = DB_OUT;
    {CS_N, IOR_STROBE_N} = 2'h3;
    @(negedge MCLK);
  endtask

  // sixteen-bit access always starts at the low byte
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(dmarc_pkg::ADR_CLR_TOG, 8'h00);
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    wr(dmarc_pkg::ADR_CLR_TOG, 8'h00);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
  endtask
endmodule // dmarc_host

//--- testbench/tb.sv
// self-checking bench for the dma register block.
// assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps

module tb;
  // ==========================================================
  // stimulus and design nets
  logic MCLK, RSTN, PROG_COND, END_OF_PROCESS_N, TEMP_LOAD, CS_N, IOR_STROBE_N, IOW_STROBE_N, DB_OE;
  logic [3:0] CHANNEL_REQUEST_IN, XFER_STEP, REG_ADDR, TERMINAL_COUNT, SERVICE_REQ, MASK_OUT;
  logic [1:0] ACTIVE_CHAN;
  logic [7:0] TEMP_DATA, DB_IN, DB_OUT, CMD_OUT;
  int fails = 0;
  int comparisons = 0;

  dmarc_top dmarc_top_i (.MCLK(MCLK), .RSTN(RSTN), .CS_N(CS_N), .IOR_STROBE_N(IOR_STROBE_N),
    .IOW_STROBE_N(IOW_STROBE_N), .REG_ADDR(REG_ADDR), .DB_IN(DB_IN), .DB_OUT(DB_OUT), .DB_OE(DB_OE),
    .PROG_COND(PROG_COND), .CHANNEL_REQUEST_IN(CHANNEL_REQUEST_IN), .XFER_STEP(XFER_STEP),
    .END_OF_PROCESS_N(END_OF_PROCESS_N), .ACTIVE_CHAN(ACTIVE_CHAN), .TEMP_LOAD(TEMP_LOAD),
    .TEMP_DATA(TEMP_DATA), .TERMINAL_COUNT(TERMINAL_COUNT), .SERVICE_REQ(SERVICE_REQ),
    .MASK_OUT(MASK_OUT), .CMD_OUT(CMD_OUT));
  dmarc_host dmarc_host_i (.MCLK(MCLK), .CS_N(CS_N), .IOR_STROBE_N(IOR_STROBE_N),
    .IOW_STROBE_N(IOW_STROBE_N), .REG_ADDR(REG_ADDR), .DB_IN(DB_IN), .DB_OUT(DB_OUT));

  // ==========================================================
  // clock, compare and verdict
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one step pulse, then count terminal count cycles seen
  task automatic step(input int c, output int n);
    n = 0;
    @(negedge MCLK) XFER_STEP = 4'(1 << c);
    @(negedge MCLK) XFER_STEP = 4'h0;
    repeat (3) begin
      n += int'(TERMINAL_COUNT[c] === 1'b1);
      @(negedge MCLK);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    chk(16'(MASK_OUT), 16'h000F);
    chk(16'(CMD_OUT), 16'h0000);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0000);
    dmarc_host_i.rd(dmarc_pkg::ADR_TEMP_MCLR, d);
    chk(16'(d), 16'h0000);
    dmarc_host_i.rd(dmarc_pkg::ADR_REQUEST, d); // write-only code reads zero
    chk(16'(d), 16'h0000);
  endtask

  // every channel address and count, distinct patterns
  task automatic t_regs();
    logic [15:0] v;
    for (int i = 0; i < 8; i++) dmarc_host_i.wr16(4'(i), 16'(16'h1357 + i * 16'h1111));
    for (int i = 0; i < 8; i++) begin
      dmarc_host_i.rd16(4'(i), v);
      chk(v, 16'(16'h1357 + i * 16'h1111));
    end
  endtask

  // channel 2 masked, software request, count runs out
  task automatic t_tc();
    logic [15:0] v;
    logic [7:0] d;
    int n;
    dmarc_host_i.wr(dmarc_pkg::ADR_MODE, 8'h82);
    dmarc_host_i.wr16(4'h5, 16'h0001);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h06);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0040);
    step(2, n);
    chk(16'(n), 16'h0000);
    step(2, n);
    chk(16'(n), 16'h0001);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0004);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0000);
    dmarc_host_i.rd16(4'h5, v);
    chk(v, 16'hFFFF);
    dmarc_host_i.wr16(4'h5, 16'h00A0);
    dmarc_host_i.rd16(4'h5, v);
    chk(v, 16'h00A0);
  endtask

  // channel 3 autoinit: reload, mask kept clear
  task automatic t_auto();
    logic [15:0] v;
    logic [7:0] d;
    int n;
    dmarc_host_i.wr(dmarc_pkg::ADR_MODE, 8'h93);
    dmarc_host_i.wr16(4'h6, 16'h1234);
    dmarc_host_i.wr16(4'h7, 16'h0000);
    dmarc_host_i.wr(dmarc_pkg::ADR_SMASK, 8'h03);
    step(3, n);
    chk(16'(n), 16'h0001);
    chk(16'(MASK_OUT), 16'h0007);
    dmarc_host_i.rd16(4'h6, v);
    chk(v, 16'h1234);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0008);
    dmarc_host_i.wr(dmarc_pkg::ADR_SMASK, 8'h07);
    chk(16'(MASK_OUT), 16'h000F);
  endtask

  // software request refusals: demand mode, memory pair
  task automatic t_soft();
    logic [7:0] d;
    dmarc_host_i.wr(dmarc_pkg::ADR_MODE, 8'h01);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h05);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0000);
    dmarc_host_i.wr(dmarc_pkg::ADR_MODE, 8'h81);
    dmarc_host_i.wr(dmarc_pkg::ADR_MODE, 8'h80);
    dmarc_host_i.wr(dmarc_pkg::ADR_STATUS_CMD, 8'h01);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h05);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h04);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0010);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h00);
    dmarc_host_i.wr(dmarc_pkg::ADR_STATUS_CMD, 8'h00);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h05);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0020);
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h01);
  endtask

  // hardware request, then external end of process on channel 0
  task automatic t_eop();
    logic [7:0] d;
    dmarc_host_i.wr(dmarc_pkg::ADR_ALL_MASK, 8'h00);
    chk(16'(MASK_OUT), 16'h0000);
    CHANNEL_REQUEST_IN = 4'h2;
    repeat (2) @(negedge MCLK);
    chk(16'(SERVICE_REQ), 16'h0002);
    dmarc_host_i.wr(dmarc_pkg::ADR_SMASK, 8'h05);
    chk(16'(SERVICE_REQ), 16'h0000);
    CHANNEL_REQUEST_IN = 4'h0;
    dmarc_host_i.wr(dmarc_pkg::ADR_REQUEST, 8'h04);
    ACTIVE_CHAN = 2'h0;
    @(negedge MCLK) END_OF_PROCESS_N = 1'b0;
    @(negedge MCLK) END_OF_PROCESS_N = 1'b1;
    repeat (2) @(negedge MCLK);
    chk(16'(MASK_OUT), 16'h0003);
    dmarc_host_i.rd(dmarc_pkg::ADR_STATUS_CMD, d);
    chk(16'(d), 16'h0000);
  endtask

  // command lockout, temporary data, master clear
  task automatic t_cmds();
    logic [15:0] v;
    logic [7:0] d;
    PROG_COND = 1'b0;
    dmarc_host_i.wr(dmarc_pkg::ADR_STATUS_CMD, 8'h5A);
    PROG_COND = 1'b1;
    chk(16'(CMD_OUT), 16'h0000);
    dmarc_host_i.wr(dmarc_pkg::ADR_STATUS_CMD, 8'hA4);
    chk(16'(CMD_OUT), 16'h00A4);
    dmarc_host_i.wr(dmarc_pkg::ADR_CLR_MASK, 8'hFF);
    chk(16'(MASK_OUT), 16'h0000);
    @(negedge MCLK) {TEMP_LOAD, TEMP_DATA} = 9'h13C;
    @(negedge MCLK) TEMP_LOAD = 1'b0;
    dmarc_host_i.rd(dmarc_pkg::ADR_TEMP_MCLR, d);
    chk(16'(d), 16'h003C);
    dmarc_host_i.wr(4'h0, 8'h77); // toggle left on high byte
    dmarc_host_i.wr(dmarc_pkg::ADR_TEMP_MCLR, 8'hC3);
    chk(16'({CMD_OUT, MASK_OUT}), 16'h000F);
    dmarc_host_i.rd(dmarc_pkg::ADR_TEMP_MCLR, d);
    chk(16'(d), 16'h0000);
    dmarc_host_i.wr(4'h0, 8'h11);
    dmarc_host_i.wr(4'h0, 8'h22);
    dmarc_host_i.rd16(4'h0, v);
    chk(v, 16'h2211);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    {RSTN, PROG_COND, END_OF_PROCESS_N, TEMP_LOAD, ACTIVE_CHAN} = 6'h18;
    {CHANNEL_REQUEST_IN, XFER_STEP, TEMP_DATA} = 16'h0000;
    repeat (3) @(negedge MCLK);
    RSTN = 1'b1;
    @(negedge MCLK);
    t_reset();
    t_regs();
    t_tc();
    t_auto();
    t_soft();
    t_eop();
    t_cmds();
    stop_test();
  end

  // about four hundred cycles expected; cut off well beyond
  initial begin
    #(20000 * 50);
    fails++;
    stop_test();
  end
endmodule // tb
